// ---- pkg/timer_cfg_pkg.sv ----
// Purpose: Shared constants and types of the timer mode and I/O control.
// Assumes: Registers sit on 32-bit Wishbone words, data in the low byte, status words up to 20 bits.
// Notes:   Mode codes and nibble layouts are shared by both design files.
package timer_cfg_pkg;
  localparam int NUM_CH = 5;
  localparam int NUM_GR = 4;
  // Word regions, selected by address bits 6:5
  localparam logic [1:0] K_MODE = 2'h0;
  localparam logic [1:0] K_IOH  = 2'h1;
  localparam logic [1:0] K_IOL  = 2'h2;
  localparam logic [1:0] K_STAT = 2'h3;
  localparam logic [2:0] PIN_SLOT = 3'h5;
  // Mode register layout and reset values
  localparam int BUF_A_BIT = 4;
  localparam int BUF_B_BIT = 5;
  localparam logic [1:0] MODE_FIXED_ONES = 2'h3;
  localparam logic [5:0] MODE_RESET      = 6'h00;
  localparam logic [5:0] MODE_MASK_CD    = 6'h3F;
  localparam logic [5:0] MODE_MASK_NOCD  = 6'h0F;
  localparam logic [7:0] IO_RESET        = 8'h00;
  // Mode field codes
  localparam logic [3:0] MD_NORMAL  = 4'h0;
  localparam logic [3:0] MD_PWM1    = 4'h2;
  localparam logic [3:0] MD_PWM2    = 4'h3;
  localparam logic [3:0] MD_PHASE1  = 4'h4;
  localparam logic [3:0] MD_PHASE2  = 4'h5;
  localparam logic [3:0] MD_PHASE3  = 4'h6;
  localparam logic [3:0] MD_PHASE4  = 4'h7;
  localparam logic [3:0] MD_RSYNC   = 4'h8;
  localparam logic [3:0] MD_CP_PEAK = 4'hD;
  localparam logic [3:0] MD_CP_BOT  = 4'hE;
  localparam logic [3:0] MD_CP_BOTH = 4'hF;
  // Capture edge codes; zero means the alternate capture source
  localparam logic [1:0] EDGE_ALT  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] ACT_HOLD  = 2'h0;
  localparam logic [1:0] ACT_ZERO  = 2'h1;
  localparam logic [1:0] ACT_ONE   = 2'h2;
  localparam logic [1:0] ACT_TOGL  = 2'h3;

  typedef enum logic [11:0] {
    MODE_NORMAL  = 12'h001,
    MODE_PWM1    = 12'h002,
    MODE_PWM2    = 12'h004,
    MODE_PHASE1  = 12'h008,
    MODE_PHASE2  = 12'h010,
    MODE_PHASE3  = 12'h020,
    MODE_PHASE4  = 12'h040,
    MODE_RSYNC   = 12'h080,
    MODE_CP_PEAK = 12'h100,
    MODE_CP_BOT  = 12'h200,
    MODE_CP_BOTH = 12'h400,
    MODE_BAD     = 12'h800
  } mode_e;

  // Channels 1 and 2 have no general registers C and D
  function automatic logic has_cd(input logic [2:0] ch);
    return (ch != 3'h1) && (ch != 3'h2);
  endfunction : has_cd

  // Codes that make channel 3 take channel 4 along
  function automatic logic pair_mode(input logic [3:0] f);
    return (f == MD_RSYNC) || (f == MD_CP_PEAK) ||
           (f == MD_CP_BOT) || (f == MD_CP_BOTH);
  endfunction : pair_mode
endpackage : timer_cfg_pkg

// ---- pkg/chan_cfg_if.sv ----
// Purpose: Carries one channel's settings to its decoder and back.
// Assumes: One instance per channel, inside the top module.
// Notes:   Results are registered inside the decoder.
`timescale 1ns/100ps
`default_nettype none
interface chan_cfg_if;
  import timer_cfg_pkg::*;
  logic [3:0]  mode_field;
  logic        buf_a;
  logic        buf_b;
  logic [15:0] io_nibs;
  mode_e       mode;
  logic [3:0]  cmp_en;
  logic [3:0]  cap_en;
  logic [7:0]  act;
  logic [7:0]  edge_sel;
  logic [3:0]  init_lvl;
  modport regs (output mode_field, buf_a, buf_b, io_nibs,
                input  mode, cmp_en, cap_en, act, edge_sel, init_lvl);
  modport dec  (input  mode_field, buf_a, buf_b, io_nibs,
                output mode, cmp_en, cap_en, act, edge_sel, init_lvl);
endinterface : chan_cfg_if
`default_nettype wire

// ---- rtl/chan_func_decode.sv ----
// Purpose: Decodes one channel's mode and register functions.
// Assumes: Settings arrive already resolved for channel pairing.
// Notes:   All results are flops, one cycle behind the settings.
`timescale 1ns/100ps
`default_nettype none
module chan_func_decode
  import timer_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  chan_cfg_if.dec  cfg
);
  logic [3:0] live;

  // Buffer pairing silences C and D
  assign live = {~cfg.buf_b, ~cfg.buf_a, 2'b11};

  // Mode field decode; reserved codes flag as bad
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg.mode <= MODE_NORMAL;
    end else begin
      case (cfg.mode_field)
        MD_NORMAL:  cfg.mode <= MODE_NORMAL;
        MD_PWM1:    cfg.mode <= MODE_PWM1;
        MD_PWM2:    cfg.mode <= MODE_PWM2;
        MD_PHASE1:  cfg.mode <= MODE_PHASE1;
        MD_PHASE2:  cfg.mode <= MODE_PHASE2;
        MD_PHASE3:  cfg.mode <= MODE_PHASE3;
        MD_PHASE4:  cfg.mode <= MODE_PHASE4;
        MD_RSYNC:   cfg.mode <= MODE_RSYNC;
        MD_CP_PEAK: cfg.mode <= MODE_CP_PEAK;
        MD_CP_BOT:  cfg.mode <= MODE_CP_BOT;
        MD_CP_BOTH: cfg.mode <= MODE_CP_BOTH;
        default:    cfg.mode <= MODE_BAD;
      endcase
    end
  end

  // One nibble per general register, A in the low nibble
  for (genvar r = 0; r < NUM_GR; r++) begin : g_gr
    logic [3:0] n;
    assign n = cfg.io_nibs[4*r +: 4];
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cfg.cmp_en[r]         <= 1'b0;
        cfg.cap_en[r]         <= 1'b0;
        cfg.act[2*r +: 2]      <= ACT_HOLD;
        cfg.edge_sel[2*r +: 2] <= EDGE_ALT;
        cfg.init_lvl[r]       <= 1'b0;
      end else begin
        cfg.cmp_en[r] <= live[r] & ~n[3];
        cfg.cap_en[r] <= live[r] & n[3];
        cfg.act[2*r +: 2] <= (live[r] & ~n[3]) ? n[1:0] : ACT_HOLD;
        cfg.init_lvl[r] <= live[r] & ~n[3] & n[2];
        if (!live[r] || !n[3] || n[2]) begin
          cfg.edge_sel[2*r +: 2] <= EDGE_ALT;
        end else if (n[1]) begin
          cfg.edge_sel[2*r +: 2] <= EDGE_BOTH;
        end else if (n[0]) begin
          cfg.edge_sel[2*r +: 2] <= EDGE_FALL;
        end else begin
          cfg.edge_sel[2*r +: 2] <= EDGE_RISE;
        end
      end
    end
  end
endmodule : chan_func_decode
`default_nettype wire

// ---- rtl/timer_mode_io_control.sv ----
// Purpose: Mode and I/O control registers of a five-channel timer.
// Assumes: Classic Wishbone slave, one byte per aligned 32-bit word, status words up to 20 bits.
// Notes:   Decoded settings and pin levels leave as registered outputs.
`timescale 1ns/100ps
`default_nettype none
module timer_mode_io_control
  import timer_cfg_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [4:0]  counter_start_i,
  input  wire logic [4:0]  counter_clear_i,
  input  wire logic [19:0] compare_match_i,
  output logic      [59:0] mode_o,
  output logic      [4:0]  buf_a_o,
  output logic      [4:0]  buf_b_o,
  output logic      [19:0] cmp_en_o,
  output logic      [19:0] cap_en_o,
  output logic      [39:0] match_act_o,
  output logic      [39:0] cap_edge_o,
  output logic      [19:0] pin_level_o
);

  typedef struct packed {
    logic       valid;
    logic [1:0] kind;
    logic [2:0] ch;
  } reg_sel_s;

  // Address decode, shared by the write and the read path
  function automatic reg_sel_s decode_addr(input logic [7:0] a);
    reg_sel_s s;
    s.kind  = a[6:5];
    s.ch    = a[4:2];
    s.valid = 1'b0;
    if (a[7] == 1'b0 && a[1:0] == 2'b00) begin
      case (s.kind)
        K_MODE:  s.valid = (s.ch < 3'(NUM_CH));
        K_IOH:   s.valid = (s.ch < 3'(NUM_CH));
        K_IOL:   s.valid = (s.ch < 3'(NUM_CH)) && has_cd(s.ch);
        K_STAT:  s.valid = (s.ch <= PIN_SLOT);
        default: s.valid = 1'b0;
      endcase
    end
    return s;
  endfunction : decode_addr

  logic [5:0]  mode_q  [NUM_CH];
  logic [7:0]  ioh_q   [NUM_CH];
  logic [7:0]  iol_q   [NUM_CH];
  logic [4:0]  buf_a_q;
  logic [4:0]  buf_b_q;
  logic [19:0] pin_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic [31:0] rdata_d;
  logic        req;
  logic        wr_fire;
  logic        rd_fire;
  logic        slave3;
  reg_sel_s    sel;

  // Bus request qualified once per access; ack drops after one cycle
  assign req     = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_fire = req & wb_we_i & wb_sel_i[0];
  assign rd_fire = req & ~wb_we_i;
  assign sel     = decode_addr(wb_adr_i);

  // Channel 4 is slaved while channel 3 runs a paired mode
  assign slave3 = pair_mode(mode_q[3][3:0]);

  // Acknowledge every access, mapped or not, one cycle after strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Mode registers; channels without C and D drop the buffer bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        mode_q[c] <= MODE_RESET;
      end
    end else if (wr_fire && sel.valid && sel.kind == K_MODE) begin
      if (has_cd(sel.ch)) begin
        mode_q[sel.ch] <= wb_dat_i[5:0] & MODE_MASK_CD;
      end else begin
        mode_q[sel.ch] <= wb_dat_i[5:0] & MODE_MASK_NOCD;
      end
    end
  end

  // Upper I/O control registers, one per channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ioh_q[c] <= IO_RESET;
      end
    end else if (wr_fire && sel.valid && sel.kind == K_IOH) begin
      ioh_q[sel.ch] <= wb_dat_i[7:0];
    end
  end

  // Lower I/O control registers exist only where C and D exist
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        iol_q[c] <= IO_RESET;
      end
    end else if (wr_fire && sel.valid && sel.kind == K_IOL) begin
      iol_q[sel.ch] <= wb_dat_i[7:0];
    end
  end

  // Read mux; unmapped words read zero, mode bits 7:6 read one
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (sel.valid) begin
      case (sel.kind)
        K_MODE: begin
          rdata_d[7:0] = {MODE_FIXED_ONES, mode_q[sel.ch]};
        end
        K_IOH: begin
          rdata_d[7:0] = ioh_q[sel.ch];
        end
        K_IOL: begin
          rdata_d[7:0] = iol_q[sel.ch];
        end
        K_STAT: begin
          if (sel.ch == PIN_SLOT) begin
            rdata_d[19:0] = pin_q;
          end else begin
            rdata_d[11:0] = mode_o[12*sel.ch +: 12];
          end
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data registered with the ack, held until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (rd_fire) begin
      dat_q <= rdata_d;
    end
  end

  // Effective buffer pairing, with slaved channel 4 taking channel 3's bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_a_q <= 5'h00;
      buf_b_q <= 5'h00;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (c == 4 && slave3) begin
          buf_a_q[c] <= mode_q[3][BUF_A_BIT];
          buf_b_q[c] <= mode_q[3][BUF_B_BIT];
        end else begin
          buf_a_q[c] <= mode_q[c][BUF_A_BIT];
          buf_b_q[c] <= mode_q[c][BUF_B_BIT];
        end
      end
    end
  end

  // One decoder and one set of pin levels per channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    chan_cfg_if u_if ();
    logic [5:0] eff;

    // Slaved channel 4 ignores its own mode field and buffer bits
    if (c == 4) begin : g_slave
      assign eff = slave3 ? mode_q[3] : mode_q[4];
    end else begin : g_own
      assign eff = mode_q[c];
    end

    assign u_if.mode_field = eff[3:0];
    assign u_if.buf_a      = eff[BUF_A_BIT];
    assign u_if.buf_b      = eff[BUF_B_BIT];
    assign u_if.io_nibs    = {iol_q[c], ioh_q[c]};

    chan_func_decode u_dec (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .cfg   (u_if)
    );

    assign mode_o[12*c +: 12]     = u_if.mode;
    assign cmp_en_o[4*c +: 4]     = u_if.cmp_en;
    assign cap_en_o[4*c +: 4]     = u_if.cap_en;
    assign match_act_o[8*c +: 8]  = u_if.act;
    assign cap_edge_o[8*c +: 8]   = u_if.edge_sel;

    // Pin level per register; a disabled register keeps its level
    for (genvar r = 0; r < NUM_GR; r++) begin : g_pin
      logic [1:0] act;
      logic       en;
      logic       pwm2;
      logic       hit;
      assign act  = u_if.act[2*r +: 2];
      assign en   = u_if.cmp_en[r];
      assign pwm2 = (u_if.mode == MODE_PWM2);
      assign hit  = compare_match_i[4*c + r];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_q[4*c + r] <= 1'b0;
        end else if (!counter_start_i[c]) begin
          // Stopped counter: a code with a match action drives its initial level
          if (en && act != ACT_HOLD) begin
            pin_q[4*c + r] <= u_if.init_lvl[r];
          end
        end else if (pwm2 && counter_clear_i[c] && en) begin
          // Clear outranks a match in the same cycle
          pin_q[4*c + r] <= u_if.init_lvl[r];
        end else if (en && hit) begin
          case (act)
            ACT_ZERO: pin_q[4*c + r] <= 1'b0;
            ACT_ONE:  pin_q[4*c + r] <= 1'b1;
            ACT_TOGL: pin_q[4*c + r] <= ~pin_q[4*c + r];
            default:  pin_q[4*c + r] <= pin_q[4*c + r];
          endcase
        end
      end
    end
  end

  // Bus and pin outputs straight from their flops
  assign wb_ack_o    = ack_q;
  assign wb_dat_o    = dat_q;
  assign buf_a_o     = buf_a_q;
  assign buf_b_o     = buf_b_q;
  assign pin_level_o = pin_q;

endmodule : timer_mode_io_control
`default_nettype wire

// ---- testbench/timer_mode_io_control_sva.sv ----
// Purpose: Port-level checks of the timer mode and I/O control block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Buffer checks look at channel 0 only, the pairing is alike.
`timescale 1ns/100ps
`default_nettype none
module timer_mode_io_control_sva
  import timer_cfg_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [59:0] mode_o,
  input wire logic [4:0]  buf_a_o,
  input wire logic [4:0]  buf_b_o,
  input wire logic [19:0] cmp_en_o,
  input wire logic [19:0] cap_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Read taken, then the mode region decode
  sequence s_take_rd;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  endsequence
  sequence s_mode_adr;
    wb_adr_i[7:5] == 3'h0 && wb_adr_i[1:0] == 2'h0 && wb_adr_i[4:2] < 3'h5;
  endsequence
  sequence s_nocd_adr;
    wb_adr_i[7:5] == 3'h0 && wb_adr_i[1:0] == 2'h0 &&
      (wb_adr_i[4:2] == 3'h1 || wb_adr_i[4:2] == 3'h2);
  endsequence
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_MODE_TOP: assert property ((s_take_rd and s_mode_adr) |=> wb_dat_o[7:6] == 2'h3)
    else $error("mode register top bits not one");
  AST_NOCD_BUF: assert property ((s_take_rd and s_nocd_adr) |=> wb_dat_o[5:4] == 2'h0)
    else $error("buffer bits of channel without C and D not zero");
  AST_MODE_ONEHOT: assert property ($onehot(mode_o[11:0]) && $onehot(mode_o[47:36]))
    else $error("mode decode not one-hot");
  AST_CH4_FOLLOW: assert property ((mode_o[47:36] & 12'h780) != 12'h000 |-> mode_o[59:48] == mode_o[47:36])
    else $error("channel 4 not following channel 3");
  AST_BUFA_QUIET: assert property (buf_a_o[0] && $past(buf_a_o[0]) |-> !cmp_en_o[2] && !cap_en_o[2])
    else $error("buffering register C still active");
  AST_BUFB_QUIET: assert property (buf_b_o[0] && $past(buf_b_o[0]) |-> !cmp_en_o[3] && !cap_en_o[3])
    else $error("buffering register D still active");
  AST_FUNC_EXCL: assert property ((cmp_en_o & cap_en_o) == 20'h00000)
    else $error("compare and capture both enabled");
endmodule : timer_mode_io_control_sva
bind timer_mode_io_control timer_mode_io_control_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .mode_o(mode_o), .buf_a_o(buf_a_o),
  .buf_b_o(buf_b_o), .cmp_en_o(cmp_en_o), .cap_en_o(cap_en_o));
`default_nettype wire

// ---- testbench/test_timer_mode_io_control.sv ----
// Purpose: Register and decode tests of the timer mode and I/O control.
// Assumes: Settings take effect within four cycles of the bus answer.
// Notes:   Software-side prohibitions are kept by the stimulus itself.
`timescale 1ns/100ps
`default_nettype none
module test_timer_mode_io_control;
  import timer_cfg_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [4:0]  counter_start_i, counter_clear_i, buf_a_o, buf_b_o;
  logic [19:0] compare_match_i, cmp_en_o, cap_en_o, pin_level_o;
  logic [59:0] mode_o;
  logic [39:0] match_act_o, cap_edge_o;
  logic [5:0]  fa, fb;
  logic [3:0]  ch;
  int          fails, compares, i;
  // Channel, mode code and expected one-hot, legal pairs only
  // Only legal channel and code pairs are loaded
  logic [19:0] tbl [11] = '{20'h00001, 20'h02002, 20'h03004, 20'h14008,
    20'h15010, 20'h26020, 20'h27040, 20'h38080, 20'h3D100, 20'h3E200,
    20'h3F400};
  timer_mode_io_control u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .counter_start_i(counter_start_i), .counter_clear_i(counter_clear_i),
    .compare_match_i(compare_match_i), .mode_o(mode_o), .buf_a_o(buf_a_o),
    .buf_b_o(buf_b_o), .cmp_en_o(cmp_en_o), .cap_en_o(cap_en_o),
    .match_act_o(match_act_o), .cap_edge_o(cap_edge_o),
    .pin_level_o(pin_level_o));
  // Free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Classic cycle; the wait is cut short only by the watchdog
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [7:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, dat};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic rd_chk(input string name, input logic [7:0] adr,
                        input logic [31:0] exp);
    bus(1'b0, adr, 8'h00);
    check(name, rd, exp);
  endtask : rd_chk
  // Decoded outputs lag the bus answer, pins one edge more
  task automatic settle();
    repeat (4) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic pulse(input logic clr);
    @(posedge clk_i);
    if (clr) counter_clear_i <= 5'h01;
    else compare_match_i <= 20'h00001;
    @(posedge clk_i);
    counter_clear_i <= 5'h00;
    compare_match_i <= 20'h00000;
    settle();
  endtask : pulse
  // Expected {cmp, cap, act, edge} of one function nibble
  function automatic logic [5:0] fn(input logic [3:0] c);
    if (!c[3]) return {2'h2, c[1:0], 2'h0};
    return {4'h4, c[2] ? 2'h0 : (c[1] ? 2'h3 : (c[0] ? 2'h2 : 2'h1))};
  endfunction : fn
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (30000) @(posedge clk_i);
    fails++;
    results();
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h00000000;
    {counter_start_i, counter_clear_i, compare_match_i} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 5; i++) begin
      rd_chk("mode reset", 8'(4 * i), 32'h000000C0);
      rd_chk("io reset", 8'(32 + 4 * i), 32'h00000000);
      check("mode_o reset", 32'(mode_o[12 * i +: 12]), 32'h001);
    end
    bus(1'b1, 8'h00, 8'hF3);
    rd_chk("mode ch0 back", 8'h00, 32'h000000F3);
    bus(1'b1, 8'h4C, 8'hA5);
    rd_chk("lower io ch3", 8'h4C, 32'h000000A5);
    bus(1'b1, 8'h44, 8'hFF);
    rd_chk("unmapped", 8'h44, 32'h00000000);
    bus(1'b1, 8'h4C, 8'h00);
    bus(1'b1, 8'h10, 8'hC2);
    for (i = 0; i < 11; i++) begin
      ch = tbl[i][19:16];
      bus(1'b1, 8'(4 * ch), {4'hC, tbl[i][15:12]});
      settle();
      check("mode_o", 32'(mode_o[12 * ch +: 12]), 32'(tbl[i][11:0]));
      rd_chk("status", 8'(96 + 4 * ch), 32'(tbl[i][11:0]));
      if (ch == 4'h3) check("ch4 mode", 32'(mode_o[48 +: 12]), 32'(tbl[i][11:0]));
    end
    bus(1'b1, 8'h0C, 8'hC0);
    bus(1'b1, 8'h04, 8'hC0);
    settle();
    check("ch4 own mode", 32'(mode_o[48 +: 12]), 32'h002);
    for (i = 0; i < 13; i++) begin
      bus(1'b1, 8'h24, {4'(i), 4'(12 - i)});
      settle();
      fa = fn(4'(12 - i));
      fb = fn(4'(i));
      check("ch1 functions", {cmp_en_o[5:4], cap_en_o[5:4], match_act_o[11:8],
        cap_edge_o[11:8]}, {fb[5], fa[5], fb[4], fa[4], fb[3:2], fa[3:2],
        fb[1:0], fa[1:0]});
    end
    bus(1'b1, 8'h00, 8'hF0);
    bus(1'b1, 8'h40, 8'h11);
    bus(1'b1, 8'h20, 8'h11);
    settle();
    check("both buffered", {buf_b_o[0], buf_a_o[0], cmp_en_o[3:0]}, 6'h33);
    bus(1'b1, 8'h00, 8'hD0);
    settle();
    check("a buffered", {buf_b_o[0], buf_a_o[0], cmp_en_o[3:0]}, 6'h1B);
    bus(1'b1, 8'h00, 8'hC0);
    bus(1'b1, 8'h20, 8'h05);
    settle();
    check("init while stopped", pin_level_o[0], 1'b1);
    @(posedge clk_i);
    counter_start_i <= 5'h01;
    pulse(1'b0);
    check("match drives zero", pin_level_o[0], 1'b0);
    pulse(1'b1);
    check("clear in normal", pin_level_o[0], 1'b0);
    @(posedge clk_i);
    counter_start_i <= 5'h00;
    bus(1'b1, 8'h00, 8'hC3);
    settle();
    @(posedge clk_i);
    counter_start_i <= 5'h01;
    pulse(1'b0);
    check("pwm2 match", pin_level_o[0], 1'b0);
    pulse(1'b1);
    check("pwm2 clear level", pin_level_o[0], 1'b1);
    // Levels left by earlier stopped-counter settings stay held
    rd_chk("pin status", 8'h74, 32'h00004021);
    results();
  end
endmodule : test_timer_mode_io_control
`default_nettype wire
